// *** rfc_params.svh ***
// Register map, reset values, field positions and scaling for the carrier registers
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define RFC_ADDR_OFS1      7'h73
`define RFC_ADDR_OFS2      7'h74
`define RFC_ADDR_BAND      7'h75
`define RFC_ADDR_FC_HI     7'h76
`define RFC_ADDR_FC_LO     7'h77
`define RFC_ADDR_MISC      7'h78
`define RFC_ADDR_HOP_CH    7'h79
`define RFC_ADDR_HOP_STEP  7'h7a
`define RFC_ADDR_TURN      7'h7b

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RFC_RST_OFS1       8'h00
`define RFC_RST_OFS2       2'h0
`define RFC_RST_BAND       7'h75
`define RFC_RST_FC_HI      8'hbb
`define RFC_RST_FC_LO      8'h80
`define RFC_RST_MISC       8'h00
`define RFC_RST_HOP_CH     8'h00
`define RFC_RST_HOP_STEP   8'h00
`define RFC_RST_TURN       8'h7b

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RFC_BAND_SB        6
`define RFC_BAND_HB        5
`define RFC_BAND_FB_MSB    4
`define RFC_MISC_ALT       3
`define RFC_MISC_TRIM_MSB  2
`define RFC_TURN_LEN       7
`define RFC_TURN_EN        2
`define RFC_TURN_PH_MSB    1
`define RFC_OFS_SIGN       9
`define RFC_SPI_WR_BIT     7
`define RFC_SPI_LAST_BIT   3'h7

// ------------------------------------------------------------
// Carrier formula scaling (result in 1/32 kHz units)
// ------------------------------------------------------------
`define RFC_BAND_BASE      24
`define RFC_BAND_KHZ       10000
`define RFC_FC_DIV         64000
`define RFC_HOP_KHZ        10
`define RFC_FRAC           32
`define RFC_LOW_MIN        7680000
`define RFC_HIGH_MIN       15360000

`endif

// *** rfc_pkg.sv ***
// Types shared by the carrier register bank
package rfc_pkg;
	typedef logic [25:0] rfc_freq_type;
	typedef enum logic {RFC_SPI_CMD, RFC_SPI_DATA} rfc_spi_state_type;
endpackage : rfc_pkg

// *** rfc_pin_sync.sv ***
// Two-flop synchroniser for the serial interface pins
`timescale 1ns/1ps
module rfc_pin_sync #(
	parameter int            W       = 3,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	import rfc_pkg::*;

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = pin_i;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;
endmodule : rfc_pin_sync

// *** rfc_freq_calc.sv ***
// Carrier frequency computation from band, carrier word, offset and hop fields
`timescale 1ns/1ps
`include "rfc_params.svh"
module rfc_freq_calc (
	input  wire logic          sys_clk_i,
	input  wire logic          nrst_i,
	input  wire logic          recalc_i,
	input  wire logic          high_band_i,
	input  wire logic [4:0]    band_index_i,
	input  wire logic [15:0]   carrier_word_i,
	input  wire logic [9:0]    freq_offset_i,
	input  wire logic [7:0]    hop_channel_i,
	input  wire logic [7:0]    hop_step_i,
	output rfc_pkg::rfc_freq_type carrier_freq_o,
	output logic               freq_update_o
);
	import rfc_pkg::*;

	localparam logic signed [31:0] BAND_SCALE = 32'(`RFC_BAND_KHZ * `RFC_FRAC);
	localparam logic signed [31:0] FC_SCALE   = 32'(`RFC_BAND_KHZ * `RFC_FRAC / `RFC_FC_DIV);
	localparam logic signed [31:0] HOP_SCALE  = 32'(`RFC_HOP_KHZ * `RFC_FRAC);
	localparam logic signed [31:0] BAND_BASE  = 32'(`RFC_BAND_BASE);

	logic signed [31:0] base_v;
	logic signed [31:0] hop_v;
	logic signed [31:0] total_v;
	rfc_freq_type       freq_r;
	rfc_freq_type       freq_nxt;
	logic               upd_r;
	logic               upd_nxt;

	// ------------------------------------------------------------
	// Formula
	// ------------------------------------------------------------
	always_comb begin
		base_v   = ($signed({27'h0, band_index_i}) + BAND_BASE) * BAND_SCALE
		         + ($signed({16'h0, carrier_word_i})
		         + $signed({{22{freq_offset_i[`RFC_OFS_SIGN]}}, freq_offset_i})) * FC_SCALE;
		hop_v    = $signed({24'h0, hop_channel_i}) * $signed({24'h0, hop_step_i}) * HOP_SCALE;
		total_v  = base_v * ($signed({31'h0, high_band_i}) + 32'sh1) + hop_v;
		freq_nxt = recalc_i ? total_v[25:0] : freq_r;
		upd_nxt  = recalc_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			freq_r <= '0;
			upd_r  <= 1'b0;
		end else begin
			freq_r <= freq_nxt;
			upd_r  <= upd_nxt;
		end
	end

	assign carrier_freq_o = freq_r;
	assign freq_update_o  = upd_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	band_zero_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		recalc_i && band_index_i == 5'h0 && carrier_word_i == 16'h0 && freq_offset_i == 10'h0
		&& hop_channel_i == 8'h0 |=> carrier_freq_o ==
		26'(`RFC_BAND_BASE * `RFC_BAND_KHZ * `RFC_FRAC * (high_band_i ? 2 : 1)))
		else $error("band zero frequency wrong");
	high_band_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		recalc_i && high_band_i && !freq_offset_i[`RFC_OFS_SIGN] && hop_channel_i == 8'h0
		|=> carrier_freq_o >= 26'(`RFC_HIGH_MIN))
		else $error("high band carrier below range");
	low_band_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		recalc_i && !high_band_i && band_index_i <= 5'h16 && !freq_offset_i[`RFC_OFS_SIGN]
		&& hop_channel_i == 8'h0
		|=> carrier_freq_o >= 26'(`RFC_LOW_MIN) && carrier_freq_o < 26'(`RFC_HIGH_MIN))
		else $error("low band carrier out of range");
	hop_shift_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		recalc_i && !high_band_i && band_index_i == 5'h0 && carrier_word_i == 16'h0
		&& freq_offset_i == 10'h0 |=> carrier_freq_o == 26'(`RFC_BAND_BASE * `RFC_BAND_KHZ
		* `RFC_FRAC) + 26'($past(hop_channel_i) * $past(hop_step_i) * `RFC_HOP_KHZ * `RFC_FRAC))
		else $error("hop channel shift wrong");
endmodule : rfc_freq_calc

// *** rfc_carrier_regs.sv ***
// Carrier frequency register bank behind the four-wire serial interface
`timescale 1ns/1ps
`include "rfc_params.svh"
module rfc_carrier_regs (
	input  wire logic          sys_clk_i,
	input  wire logic          nrst_i,
	input  wire logic          sclk_i,
	input  wire logic          sdi_i,
	input  wire logic          nsel_i,
	input  wire logic [9:0]    afc_offset_i,
	output logic               sdo_o,
	output rfc_pkg::rfc_freq_type carrier_freq_o,
	output logic               freq_update_o,
	output logic               high_band_o,
	output logic               side_band_o,
	output logic               alt_amp_sequence_o,
	output logic [2:0]         rcosc_trim_o,
	output logic               length_incl_crc_o,
	output logic               turn_around_en_o,
	output logic [1:0]         turn_phase_o
);
	import rfc_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------
	logic [2:0] pin_s;
	logic       sclk_s;
	logic       sdi_s;
	logic       sel;
	logic       sclk_d_r;
	logic       sclk_d_nxt;
	logic       sclk_rise;
	logic       sclk_fall;

	rfc_pin_sync #(
		.W       (3),
		.RST_VAL (3'h1)
	) rfc_pin_sync_inst (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.pin_i     ({sclk_i, sdi_i, nsel_i}),
		.sync_o    (pin_s)
	);

	always_comb begin
		sclk_s     = pin_s[2];
		sdi_s      = pin_s[1];
		sel        = ~pin_s[0];
		sclk_d_nxt = sclk_s;
		sclk_rise  = sclk_s & ~sclk_d_r;
		sclk_fall  = ~sclk_s & sclk_d_r;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
		end
	end

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] ofs1_r, ofs1_nxt;
	logic [1:0] ofs2_r, ofs2_nxt;
	logic [6:0] band_r, band_nxt;
	logic [7:0] fc_hi_r, fc_hi_nxt;
	logic [7:0] fc_lo_r, fc_lo_nxt;
	logic [7:0] misc_r, misc_nxt;
	logic [7:0] hop_ch_r, hop_ch_nxt;
	logic [7:0] hop_step_r, hop_step_nxt;
	logic [7:0] turn_r, turn_nxt;
	logic       recalc_r, recalc_nxt;

	// ------------------------------------------------------------
	// Serial framing
	// ------------------------------------------------------------
	rfc_spi_state_type st_r, st_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic       wr_mode_r, wr_mode_nxt;
	logic [6:0] addr_r, addr_nxt;
	logic [7:0] rd_sh_r, rd_sh_nxt;
	logic       sdo_r, sdo_nxt;
	logic [7:0] byte_in;
	logic       byte_done;
	logic       wr_en;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;

	function automatic logic is_freq_field(input logic [6:0] a);
		is_freq_field = (a >= `RFC_ADDR_OFS1 && a <= `RFC_ADDR_FC_LO)
		             || a == `RFC_ADDR_HOP_CH || a == `RFC_ADDR_HOP_STEP;
	endfunction : is_freq_field

	always_comb begin
		byte_in   = {sh_r[6:0], sdi_s};
		byte_done = sel && sclk_rise && bit_cnt_r == `RFC_SPI_LAST_BIT;
		wr_en     = byte_done && st_r == RFC_SPI_DATA && wr_mode_r;
		rd_addr   = (st_r == RFC_SPI_CMD) ? byte_in[6:0] : addr_r + 7'h1;
		case (rd_addr)
			`RFC_ADDR_OFS1:     rd_data = afc_offset_i[7:0];
			`RFC_ADDR_OFS2:     rd_data = {6'h0, afc_offset_i[9:8]};
			`RFC_ADDR_BAND:     rd_data = {1'b0, band_r};
			`RFC_ADDR_FC_HI:    rd_data = fc_hi_r;
			`RFC_ADDR_FC_LO:    rd_data = fc_lo_r;
			`RFC_ADDR_MISC:     rd_data = misc_r;
			`RFC_ADDR_HOP_CH:   rd_data = hop_ch_r;
			`RFC_ADDR_HOP_STEP: rd_data = hop_step_r;
			`RFC_ADDR_TURN:     rd_data = turn_r;
			default:            rd_data = 8'h00;
		endcase
		st_nxt      = st_r;
		bit_cnt_nxt = bit_cnt_r;
		sh_nxt      = sh_r;
		wr_mode_nxt = wr_mode_r;
		addr_nxt    = addr_r;
		rd_sh_nxt   = rd_sh_r;
		sdo_nxt     = sdo_r;
		if (!sel) begin
			st_nxt      = RFC_SPI_CMD;
			bit_cnt_nxt = 3'h0;
		end else if (sclk_rise) begin
			sh_nxt      = byte_in;
			bit_cnt_nxt = bit_cnt_r + 3'h1;
			if (byte_done) begin
				rd_sh_nxt = rd_data;
				case (st_r)
					RFC_SPI_CMD: begin
						wr_mode_nxt = byte_in[`RFC_SPI_WR_BIT];
						addr_nxt    = byte_in[6:0];
						st_nxt      = RFC_SPI_DATA;
					end
					RFC_SPI_DATA: begin
						addr_nxt = addr_r + 7'h1;
					end
					default: begin
						st_nxt = RFC_SPI_CMD;
					end
				endcase
			end
		end else if (sclk_fall && st_r == RFC_SPI_DATA && !wr_mode_r) begin
			sdo_nxt   = rd_sh_r[7];
			rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st_r      <= RFC_SPI_CMD;
			bit_cnt_r <= 3'h0;
			sh_r      <= 8'h00;
			wr_mode_r <= 1'b0;
			addr_r    <= 7'h00;
			rd_sh_r   <= 8'h00;
			sdo_r     <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			sh_r      <= sh_nxt;
			wr_mode_r <= wr_mode_nxt;
			addr_r    <= addr_nxt;
			rd_sh_r   <= rd_sh_nxt;
			sdo_r     <= sdo_nxt;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		ofs1_nxt     = ofs1_r;
		ofs2_nxt     = ofs2_r;
		band_nxt     = band_r;
		fc_hi_nxt    = fc_hi_r;
		fc_lo_nxt    = fc_lo_r;
		misc_nxt     = misc_r;
		hop_ch_nxt   = hop_ch_r;
		hop_step_nxt = hop_step_r;
		turn_nxt     = turn_r;
		recalc_nxt   = wr_en && is_freq_field(addr_r);
		if (wr_en) begin
			case (addr_r)
				`RFC_ADDR_OFS1:     ofs1_nxt     = byte_in;
				`RFC_ADDR_OFS2:     ofs2_nxt     = byte_in[1:0];
				`RFC_ADDR_BAND:     band_nxt     = byte_in[6:0];
				`RFC_ADDR_FC_HI:    fc_hi_nxt    = byte_in;
				`RFC_ADDR_FC_LO:    fc_lo_nxt    = byte_in;
				`RFC_ADDR_MISC:     misc_nxt     = byte_in;
				`RFC_ADDR_HOP_CH:   hop_ch_nxt   = byte_in;
				`RFC_ADDR_HOP_STEP: hop_step_nxt = byte_in;
				`RFC_ADDR_TURN:     turn_nxt     = byte_in;
				default:            turn_nxt     = turn_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			ofs1_r     <= `RFC_RST_OFS1;
			ofs2_r     <= `RFC_RST_OFS2;
			band_r     <= `RFC_RST_BAND;
			fc_hi_r    <= `RFC_RST_FC_HI;
			fc_lo_r    <= `RFC_RST_FC_LO;
			misc_r     <= `RFC_RST_MISC;
			hop_ch_r   <= `RFC_RST_HOP_CH;
			hop_step_r <= `RFC_RST_HOP_STEP;
			turn_r     <= `RFC_RST_TURN;
			recalc_r   <= 1'b1;
		end else begin
			ofs1_r     <= ofs1_nxt;
			ofs2_r     <= ofs2_nxt;
			band_r     <= band_nxt;
			fc_hi_r    <= fc_hi_nxt;
			fc_lo_r    <= fc_lo_nxt;
			misc_r     <= misc_nxt;
			hop_ch_r   <= hop_ch_nxt;
			hop_step_r <= hop_step_nxt;
			turn_r     <= turn_nxt;
			recalc_r   <= recalc_nxt;
		end
	end

	// ------------------------------------------------------------
	// Frequency computation
	// ------------------------------------------------------------
	rfc_freq_calc rfc_freq_calc_inst (
		.sys_clk_i      (sys_clk_i),
		.nrst_i         (nrst_i),
		.recalc_i       (recalc_r),
		.high_band_i    (band_r[`RFC_BAND_HB]),
		.band_index_i   (band_r[`RFC_BAND_FB_MSB:0]),
		.carrier_word_i ({fc_hi_r, fc_lo_r}),
		.freq_offset_i  ({ofs2_r, ofs1_r}),
		.hop_channel_i  (hop_ch_r),
		.hop_step_i     (hop_step_r),
		.carrier_freq_o (carrier_freq_o),
		.freq_update_o  (freq_update_o)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sdo_o              = sdo_r;
	assign high_band_o        = band_r[`RFC_BAND_HB];
	assign side_band_o        = band_r[`RFC_BAND_SB];
	assign alt_amp_sequence_o = misc_r[`RFC_MISC_ALT];
	assign rcosc_trim_o       = misc_r[`RFC_MISC_TRIM_MSB:0];
	assign length_incl_crc_o  = turn_r[`RFC_TURN_LEN];
	assign turn_around_en_o   = turn_r[`RFC_TURN_EN];
	assign turn_phase_o       = turn_r[`RFC_TURN_PH_MSB:0];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	band_rst_a: assert property (@(posedge sys_clk_i) $rose(nrst_i)
		|-> {1'b0, band_r} == 8'h75 && high_band_o && side_band_o)
		else $error("band select reset value wrong");
	carrier_rst_a: assert property (@(posedge sys_clk_i) $rose(nrst_i)
		|-> fc_hi_r == `RFC_RST_FC_HI && fc_lo_r == `RFC_RST_FC_LO)
		else $error("carrier word reset value wrong");
	hop_rst_a: assert property (@(posedge sys_clk_i) $rose(nrst_i)
		|-> hop_ch_r == 8'h00)
		else $error("hop channel reset value wrong");
	turn_rst_a: assert property (@(posedge sys_clk_i) $rose(nrst_i)
		|-> turn_r == `RFC_RST_TURN && length_incl_crc_o == 1'b0)
		else $error("turn-around reset value wrong");
	alt_off_a: assert property (@(posedge sys_clk_i) $rose(nrst_i)
		|-> !alt_amp_sequence_o ##1 (!alt_amp_sequence_o || $past(wr_en)))
		else $error("alternative sequencing not off after reset");
	band_write_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en && addr_r == `RFC_ADDR_BAND |=> band_r == $past(byte_in[6:0]))
		else $error("band select write lost");
	fc_split_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en && addr_r == `RFC_ADDR_FC_HI |=> fc_hi_r == $past(byte_in) && $stable(fc_lo_r))
		else $error("carrier upper byte write wrong");
	len_crc_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en && addr_r == `RFC_ADDR_TURN |=> length_incl_crc_o == $past(byte_in[7]))
		else $error("length compliance bit not stored");
	recalc_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en && is_freq_field(addr_r) |-> !freq_update_o ##2 freq_update_o)
		else $error("frequency not recomputed after write");
	no_recalc_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en && !is_freq_field(addr_r) && !recalc_r |=> ##1 !freq_update_o)
		else $error("spurious frequency update");

	wr_burst_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		wr_en ##[1:300] wr_en);
	rd_byte_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		byte_done && st_r == RFC_SPI_DATA && !wr_mode_r);
	hb_upd_c: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		freq_update_o && high_band_o);
endmodule : rfc_carrier_regs

// *** rfc_host_model.sv ***
// Host controller model driving the four-wire serial interface
`timescale 1ns/1ps
module rfc_host_model (
	input  wire logic sys_clk_i,
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      sdi_o,
	output logic      nsel_o
);
	// ------------------------------------------------------------
	// Idle levels: clock still, select high
	// ------------------------------------------------------------
	initial begin
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
		nsel_o = 1'b1;
	end

	// ------------------------------------------------------------
	// One bit: data, rise with sample, fall
	// ------------------------------------------------------------
	task automatic bit_x(input logic b, output logic r);
		@(posedge sys_clk_i) sdi_o <= b;
		repeat (6) @(posedge sys_clk_i);
		sclk_o <= 1'b1;
		r = sdo_i;
		repeat (6) @(posedge sys_clk_i);
		sclk_o <= 1'b0;
	endtask : bit_x

	// ------------------------------------------------------------
	// One frame: command byte then one data byte
	// ------------------------------------------------------------
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic r;
		@(posedge sys_clk_i) nsel_o <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		for (int i = 7; i >= 0; i--) begin
			bit_x(cmd[i], r);
		end
		for (int i = 7; i >= 0; i--) begin
			bit_x(wd[i], r);
			rd[i] = r;
		end
		repeat (6) @(posedge sys_clk_i);
		nsel_o <= 1'b1;
		sdi_o  <= ~sdi_o;
		repeat (6) @(posedge sys_clk_i);
	endtask : xfer

	// ------------------------------------------------------------
	// Burst frame: command byte then two data bytes
	// ------------------------------------------------------------
	task automatic xfer2(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
		logic r;
		@(posedge sys_clk_i) nsel_o <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		for (int i = 7; i >= 0; i--) begin
			bit_x(cmd[i], r);
		end
		for (int i = 15; i >= 0; i--) begin
			bit_x(wd[i], r);
			rd[i] = r;
		end
		repeat (6) @(posedge sys_clk_i);
		nsel_o <= 1'b1;
		sdi_o  <= ~sdi_o;
		repeat (6) @(posedge sys_clk_i);
	endtask : xfer2
endmodule : rfc_host_model

// *** rfc_carrier_regs_tb.sv ***
// Self-checking testbench for the carrier register bank
`timescale 1ns/1ps
module rfc_carrier_regs_tb;
	import rfc_pkg::*;
	logic         sys_clk_i;
	logic         nrst_i;
	logic [9:0]   afc_offset_i;
	logic         sclk;
	logic         sdi;
	logic         nsel;
	logic         sdo;
	rfc_freq_type freq;
	logic         upd;
	logic         hb;
	logic         sb;
	logic         alt;
	logic [2:0]   trim;
	logic         lcrc;
	logic         ta_en;
	logic [1:0]   ta_ph;
	int           n_fail;
	int           tests_run;
	int           n_upd;
	int           cycles;
	logic [7:0]   d;

	rfc_carrier_regs rfc_carrier_regs_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.sclk_i(sclk), .sdi_i(sdi), .nsel_i(nsel), .afc_offset_i(afc_offset_i),
		.sdo_o(sdo), .carrier_freq_o(freq), .freq_update_o(upd), .high_band_o(hb),
		.side_band_o(sb), .alt_amp_sequence_o(alt), .rcosc_trim_o(trim),
		.length_incl_crc_o(lcrc), .turn_around_en_o(ta_en), .turn_phase_o(ta_ph));
	rfc_host_model rfc_host_model_inst (.sys_clk_i(sys_clk_i), .sdo_i(sdo),
		.sclk_o(sclk), .sdi_o(sdi), .nsel_o(nsel));

	// ------------------------------------------------------------
	// Clock, update counter, hang guard
	// ------------------------------------------------------------
	initial sys_clk_i = 1'b0;
	always #12.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (upd === 1'b1) begin
			n_upd <= n_upd + 1;
		end
		if (cycles > 30000) begin
			n_fail++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8

	task automatic chkf(input logic [25:0] exp);
		tests_run++;
		if (freq !== exp) begin
			n_fail++;
			$display("[FAIL] %0t carrier got %0d exp %0d", $time, freq, exp);
		end
	endtask : chkf

	function automatic logic [25:0] ef(int h, int b, int c, int o, int ch, int st);
		return 26'(((b + 24) * 320000 + (c + o) * 5) * (h + 1) + ch * st * 320);
	endfunction : ef

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] r;
		rfc_host_model_inst.xfer({1'b1, a}, v, r);
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		rfc_host_model_inst.xfer({1'b0, a}, 8'h00, v);
	endtask : rd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] ex[5] = '{8'h75, 8'hbb, 8'h80, 8'h00, 8'h7b};
		logic [6:0] ad[5] = '{7'h75, 7'h76, 7'h77, 7'h79, 7'h7b};
		chkf(ef(1, 21, 'hbb80, 0, 0, 0));
		for (int i = 0; i < 5; i++) begin
			rd(ad[i], d);
			chk8(d, ex[i], "reset value");
		end
		chk8({hb, sb, alt, lcrc, ta_en, ta_ph}, 8'h63, "reset flags");
	endtask : t_reset

	task automatic t_bands();
		logic [7:0] v[5] = '{8'h00, 8'h01, 8'h17, 8'h20, 8'h21};
		wr(7'h76, 8'h00);
		wr(7'h77, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(7'h75, v[i]);
			chkf(ef(v[i][5], v[i][4:0], 0, 0, 0, 0));
			chk8(hb, v[i][5], "high band");
		end
		wr(7'h75, 8'hff);
		rd(7'h75, d);
		chk8(d, 8'h7f, "band readback");
		chk8({hb, sb}, 2'h3, "band flags");
		chkf(ef(1, 31, 0, 0, 0, 0));
	endtask : t_bands

	task automatic t_word_offset();
		wr(7'h75, 8'h00);
		wr(7'h76, 8'h01);
		wr(7'h77, 8'h02);
		chkf(ef(0, 0, 258, 0, 0, 0));
		wr(7'h73, 8'hff);
		wr(7'h74, 8'h03);
		chkf(ef(0, 0, 258, -1, 0, 0));
		wr(7'h74, 8'h01);
		chkf(ef(0, 0, 258, 511, 0, 0));
		wr(7'h75, 8'h20);
		chkf(ef(1, 0, 258, 511, 0, 0));
		@(posedge sys_clk_i) afc_offset_i <= 10'h2a5;
		rd(7'h73, d);
		chk8(d, 8'ha5, "offset low read");
		rd(7'h74, d);
		chk8(d, 8'h02, "offset high read");
		wr(7'h73, 8'h00);
		wr(7'h74, 8'h00);
	endtask : t_word_offset

	task automatic t_hop();
		int n0;
		n0 = n_upd;
		wr(7'h79, 8'h03);
		chk8(8'(n_upd - n0), 8'h01, "update pulses");
		wr(7'h7a, 8'h07);
		chkf(ef(1, 0, 258, 0, 3, 7));
		wr(7'h79, 8'hff);
		wr(7'h7a, 8'hff);
		chkf(ef(1, 0, 258, 0, 255, 255));
		rd(7'h7a, d);
		chk8(d, 8'hff, "hop step read");
	endtask : t_hop

	task automatic t_misc();
		logic [7:0] t;
		rd(7'h78, t);
		chk8(t, 8'h00, "misc reset");
		wr(7'h78, {4'h0, 1'b1, t[2:0]});
		chk8({alt, trim}, {1'b1, t[2:0]}, "alt sequence on");
		wr(7'h78, {4'h0, 1'b0, t[2:0]});
		chk8(alt, 1'b0, "alt sequence off");
		wr(7'h7b, 8'h84);
		chk8({lcrc, ta_en, ta_ph}, 4'hc, "turn set");
		rd(7'h7b, d);
		chk8(d, 8'h84, "turn read");
		wr(7'h7b, 8'h03);
		chk8({lcrc, ta_en, ta_ph}, 4'h3, "turn clear");
	endtask : t_misc

	task automatic t_unmapped();
		wr(7'h10, 8'hff);
		rd(7'h10, d);
		chk8(d, 8'h00, "unmapped read");
		chkf(ef(1, 0, 258, 0, 255, 255));
	endtask : t_unmapped

	task automatic t_burst();
		int          n0;
		logic [15:0] r;
		wr(7'h75, 8'h00);
		chkf(ef(0, 0, 258, 0, 255, 255));
		rfc_host_model_inst.xfer2({1'b1, 7'h76}, 16'h0000, r);
		chkf(ef(0, 0, 0, 0, 255, 255));
		n0 = n_upd;
		rfc_host_model_inst.xfer2({1'b1, 7'h76}, 16'h1234, r);
		chk8(8'(n_upd - n0), 8'h02, "burst update pulses");
		chkf(ef(0, 0, 'h1234, 0, 255, 255));
		rfc_host_model_inst.xfer2({1'b0, 7'h76}, 16'h0000, r);
		chk8(r[15:8], 8'h12, "burst upper byte read");
		chk8(r[7:0], 8'h34, "burst lower byte read");
	endtask : t_burst

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nrst_i = 1'b0;
		afc_offset_i = 10'h000;
		n_fail = 0;
		tests_run = 0;
		n_upd = 0;
		cycles = 0;
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		t_reset();
		t_bands();
		t_word_offset();
		t_hop();
		t_misc();
		t_unmapped();
		t_burst();
		final_report();
	end
endmodule : rfc_carrier_regs_tb
